// ===== common/gpfs_pkg.sv
package gpfs_pkg;

  // command bytes that matter to the pin settings
  localparam logic [7:0] CMD_SET_SETTINGS = 8'h60;
  localparam logic [7:0] RESP_OK = 8'h00;
  localparam logic [7:0] RESP_BAD_CMD = 8'h01;
  localparam int BYTE_CMD = 0;
  localparam int BYTE_ALTER = 7;
  localparam int BYTE_PIN_FIRST = 9;
  localparam int NUM_PINS = 3;
  localparam int CMD_BYTES = 12;
  localparam int ALTER_FLAG_BIT = 7;

  // settings byte layout
  localparam int SET_OUT_BIT = 4;
  localparam int SET_DIR_BIT = 3;
  localparam int SET_FUNC_MSB = 2;
  localparam int SET_FUNC_LSB = 0;

  // register port map (byte wide data)
  localparam logic [7:0] ADDR_CMD_FIRST = 8'h00;
  localparam logic [7:0] ADDR_CMD_LAST = 8'h0b;
  localparam logic [7:0] ADDR_CONTROL = 8'h10;
  localparam logic [7:0] ADDR_RESP0 = 8'h20;
  localparam logic [7:0] ADDR_RESP1 = 8'h21;
  localparam logic [7:0] ADDR_PIN_SET_FIRST = 8'h31;
  localparam logic [7:0] ADDR_PIN_SET_LAST = 8'h33;
  localparam logic [7:0] ADDR_PIN_LEVELS = 8'h34;
  localparam int CTRL_GO_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_RESP_BIT = 1;

  // function select codes
  localparam logic [2:0] FUNC_GPIO = 3'h0;
  localparam logic [2:0] FUNC_DEDICATED = 3'h1;
  localparam logic [2:0] FUNC_ANALOG_IN = 3'h2;
  localparam logic [2:0] FUNC_ALT_ONE = 3'h3;
  localparam logic [2:0] FUNC_EDGE_IRQ = 3'h4;

  // one pin's run-time settings, bits 7-5 of the byte are dropped
  typedef struct packed {
    logic out_val;
    logic dir_in;
    logic [2:0] func;
  } gpfs_pin_set_type;

  // reset: general purpose input, output level low
  localparam gpfs_pin_set_type PIN_SET_RESET = '{out_val: 1'b0, dir_in: 1'b1, func: 3'h0};

  // what a pin cell drives, all registered
  typedef struct packed {
    logic pad_out;
    logic pad_oe;
    logic ain_en;
    logic aout_en;
    logic edge_en;
    logic in_level;
  } gpfs_pin_drive_type;

  localparam gpfs_pin_drive_type PIN_DRIVE_RESET = '0;

  // command sequencer, gray along the path
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CHECK = 2'b01,
    ST_APPLY = 2'b11,
    ST_REPLY = 2'b10
  } gpfs_state_type;

endpackage

// ===== core/gpfs_pin_cell.sv
`timescale 1ns/100ps
module gpfs_pin_cell #(
  parameter bit ALT_ONE_DIGITAL = 1'b0, // code 011 drives a digital source
  parameter bit HAS_EDGE_IRQ = 1'b0 // code 100 routes to edge detector
) (
  input wire logic clk, // system clock
  input wire logic rst, // synchronous reset, active high
  input wire gpfs_pkg::gpfs_pin_set_type set, // current run-time settings
  input wire logic ded_level, // dedicated function level, code 001
  input wire logic alt_level, // digital alternate level, code 011
  input wire logic pad_in, // pad input level
  output gpfs_pkg::gpfs_pin_drive_type drive // registered pad controls
);

  gpfs_pkg::gpfs_pin_drive_type drive_reg;
  gpfs_pkg::gpfs_pin_drive_type drive_next;

  // route the pad by function; unused codes leave the pad floating as input
  always_comb begin
    drive_next = gpfs_pkg::PIN_DRIVE_RESET;
    drive_next.in_level = pad_in;
    case (set.func)
      gpfs_pkg::FUNC_GPIO: begin
        drive_next.pad_oe = ~set.dir_in;
        drive_next.pad_out = set.out_val;
      end
      gpfs_pkg::FUNC_DEDICATED: begin
        drive_next.pad_oe = 1'b1;
        drive_next.pad_out = ded_level;
      end
      gpfs_pkg::FUNC_ANALOG_IN: begin
        drive_next.ain_en = 1'b1;
      end
      gpfs_pkg::FUNC_ALT_ONE: begin
        if (ALT_ONE_DIGITAL) begin
          drive_next.pad_oe = 1'b1;
          drive_next.pad_out = alt_level;
        end else begin
          drive_next.aout_en = 1'b1;
        end
      end
      gpfs_pkg::FUNC_EDGE_IRQ: begin
        drive_next.edge_en = HAS_EDGE_IRQ;
      end
      default: begin
        drive_next.pad_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      drive_reg <= gpfs_pkg::PIN_DRIVE_RESET;
    end else begin
      drive_reg <= drive_next;
    end
  end

  assign drive = drive_reg;

  chk_gpio_out_level: assert property (@(posedge clk) disable iff (rst)
    (set.func == gpfs_pkg::FUNC_GPIO && !set.dir_in) |=> (drive.pad_oe && drive.pad_out == $past(set.out_val)))
    else $error("gpio output not driving stored level");
  chk_gpio_dir_in: assert property (@(posedge clk) disable iff (rst)
    (set.func == gpfs_pkg::FUNC_GPIO && set.dir_in) |=> !drive.pad_oe)
    else $error("gpio input still driving pad");
  chk_analog_no_drive: assert property (@(posedge clk) disable iff (rst)
    (set.func == gpfs_pkg::FUNC_ANALOG_IN) |=> (drive.ain_en && !drive.pad_oe))
    else $error("analog input pin driven or not enabled");

endmodule

// ===== core/gpfs_pin_function_select.sv
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/100ps
module gpfs_pin_function_select (
  input wire logic clk, // system clock, 100 MHz
  input wire logic rst, // synchronous reset, active high
  input wire logic [7:0] addr, // register address
  input wire logic [7:0] wdata, // register write data
  input wire logic wr_en, // write strobe, one cycle
  input wire logic rd_en, // read strobe, one cycle
  output logic [7:0] rdata, // read data, cycle after rd_en
  output logic resp_valid, // pulse when a reply is ready
  input wire logic [2:0] pad_in, // pad input levels, index 0 is first pin
  output logic [2:0] pad_out, // pad output levels
  output logic [2:0] pad_oe, // pad output enables, high drives
  input wire logic clock_out_level, // clock output source
  input wire logic transmit_activity_indicator, // tx activity led source
  input wire logic usb_configured_indicator, // usb configured source
  input wire logic serial_bus_activity_indicator, // serial bus led source
  output logic analog_input_one, // analog input one owns first pin
  output logic analog_input_two, // analog input two owns second pin
  output logic analog_input_three, // analog input three owns third pin
  output logic analog_output_one, // analog output one owns second pin
  output logic analog_output_two, // analog output two owns third pin
  output logic edge_input_en, // edge detector owns first pin
  output logic edge_input_level // first pin level for the edge detector
);

  // command buffer as the bridge wrote it
  logic [7:0] cmd_reg [gpfs_pkg::CMD_BYTES];
  logic [7:0] cmd_next [gpfs_pkg::CMD_BYTES];
  gpfs_pkg::gpfs_pin_set_type set_reg [gpfs_pkg::NUM_PINS];
  gpfs_pkg::gpfs_pin_set_type set_next [gpfs_pkg::NUM_PINS];
  gpfs_pkg::gpfs_state_type state_reg;
  gpfs_pkg::gpfs_state_type state_next;
  logic cmd_ok_reg;
  logic cmd_ok_next;
  logic [7:0] resp0_reg;
  logic [7:0] resp0_next;
  logic [7:0] resp1_reg;
  logic [7:0] resp1_next;
  logic resp_ready_reg;
  logic resp_ready_next;
  logic resp_valid_reg;
  logic resp_valid_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  gpfs_pkg::gpfs_pin_drive_type drive [gpfs_pkg::NUM_PINS];
  logic [2:0] ded_src;
  logic [2:0] alt_src;
  logic go;

  // address in the command buffer window
  function automatic logic in_cmd(input logic [7:0] a);
    in_cmd = (a >= gpfs_pkg::ADDR_CMD_FIRST) && (a <= gpfs_pkg::ADDR_CMD_LAST);
  endfunction

  // address in the pin settings readback window
  function automatic logic in_pin_set(input logic [7:0] a);
    in_pin_set = (a >= gpfs_pkg::ADDR_PIN_SET_FIRST) && (a <= gpfs_pkg::ADDR_PIN_SET_LAST);
  endfunction

  // a go while busy is dropped so a half-applied command cannot restart
  assign go = wr_en && (addr == gpfs_pkg::ADDR_CONTROL) && wdata[gpfs_pkg::CTRL_GO_BIT]
    && (state_reg == gpfs_pkg::ST_IDLE);

  // command buffer writes; frozen while a command runs
  always_comb begin
    for (int i = 0; i < gpfs_pkg::CMD_BYTES; i++) begin
      cmd_next[i] = cmd_reg[i];
    end
    if (wr_en && in_cmd(addr) && state_reg == gpfs_pkg::ST_IDLE) begin
      cmd_next[addr[3:0]] = wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < gpfs_pkg::CMD_BYTES; i++) begin
        cmd_reg[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < gpfs_pkg::CMD_BYTES; i++) begin
        cmd_reg[i] <= cmd_next[i];
      end
    end
  end

  // sequencer: check the code, apply settings, post the reply
  always_comb begin
    state_next = state_reg;
    cmd_ok_next = cmd_ok_reg;
    resp0_next = resp0_reg;
    resp1_next = resp1_reg;
    resp_ready_next = resp_ready_reg;
    resp_valid_next = 1'b0;
    for (int p = 0; p < gpfs_pkg::NUM_PINS; p++) begin
      set_next[p] = set_reg[p];
    end
    if (go) begin
      resp_ready_next = 1'b0;
    end
    case (state_reg)
      gpfs_pkg::ST_IDLE: begin
        if (go) begin
          state_next = gpfs_pkg::ST_CHECK;
        end
      end
      gpfs_pkg::ST_CHECK: begin
        cmd_ok_next = (cmd_reg[gpfs_pkg::BYTE_CMD] == gpfs_pkg::CMD_SET_SETTINGS);
        state_next = gpfs_pkg::ST_APPLY;
      end
      gpfs_pkg::ST_APPLY: begin
        if (cmd_ok_reg && cmd_reg[gpfs_pkg::BYTE_ALTER][gpfs_pkg::ALTER_FLAG_BIT]) begin
          // all pins in one cycle, upper bits dropped
          for (int p = 0; p < gpfs_pkg::NUM_PINS; p++) begin
            set_next[p].out_val = cmd_reg[gpfs_pkg::BYTE_PIN_FIRST + p][gpfs_pkg::SET_OUT_BIT];
            set_next[p].dir_in = cmd_reg[gpfs_pkg::BYTE_PIN_FIRST + p][gpfs_pkg::SET_DIR_BIT];
            set_next[p].func = cmd_reg[gpfs_pkg::BYTE_PIN_FIRST + p]
              [gpfs_pkg::SET_FUNC_MSB:gpfs_pkg::SET_FUNC_LSB];
          end
        end
        state_next = gpfs_pkg::ST_REPLY;
      end
      gpfs_pkg::ST_REPLY: begin
        resp0_next = cmd_reg[gpfs_pkg::BYTE_CMD];
        resp1_next = cmd_ok_reg ? gpfs_pkg::RESP_OK : gpfs_pkg::RESP_BAD_CMD;
        resp_ready_next = 1'b1;
        resp_valid_next = 1'b1;
        state_next = gpfs_pkg::ST_IDLE;
      end
      default: begin
        state_next = gpfs_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= gpfs_pkg::ST_IDLE;
      cmd_ok_reg <= 1'b0;
      resp0_reg <= 8'h00;
      resp1_reg <= 8'h00;
      resp_ready_reg <= 1'b0;
      resp_valid_reg <= 1'b0;
      for (int p = 0; p < gpfs_pkg::NUM_PINS; p++) begin
        set_reg[p] <= gpfs_pkg::PIN_SET_RESET;
      end
    end else begin
      state_reg <= state_next;
      cmd_ok_reg <= cmd_ok_next;
      resp0_reg <= resp0_next;
      resp1_reg <= resp1_next;
      resp_ready_reg <= resp_ready_next;
      resp_valid_reg <= resp_valid_next;
      for (int p = 0; p < gpfs_pkg::NUM_PINS; p++) begin
        set_reg[p] <= set_next[p];
      end
    end
  end

  // read mux; unmapped addresses answer zero
  always_comb begin
    rdata_next = 8'h00;
    if (rd_en) begin
      if (in_cmd(addr)) begin
        rdata_next = cmd_reg[addr[3:0]];
      end else if (addr == gpfs_pkg::ADDR_CONTROL) begin
        rdata_next[gpfs_pkg::STAT_BUSY_BIT] = (state_reg != gpfs_pkg::ST_IDLE);
        rdata_next[gpfs_pkg::STAT_RESP_BIT] = resp_ready_reg;
      end else if (addr == gpfs_pkg::ADDR_RESP0) begin
        rdata_next = resp0_reg;
      end else if (addr == gpfs_pkg::ADDR_RESP1) begin
        rdata_next = resp1_reg;
      end else if (in_pin_set(addr)) begin
        rdata_next = {3'h0, set_reg[2'(addr[1:0] - 2'h1)]};
      end else if (addr == gpfs_pkg::ADDR_PIN_LEVELS) begin
        rdata_next = {5'h00, drive[2].in_level, drive[1].in_level, drive[0].in_level};
      end else begin
        rdata_next = 8'h00;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // sources per pin: clock/txled, usb indicator, bus led
  assign ded_src = {serial_bus_activity_indicator, usb_configured_indicator, clock_out_level};
  assign alt_src = {1'b0, 1'b0, transmit_activity_indicator};

  // one cell per pin; only the first pin has a digital 011 and an edge input
  for (genvar p = 0; p < gpfs_pkg::NUM_PINS; p++) begin : g_pin
    gpfs_pin_cell #(
      .ALT_ONE_DIGITAL(p == 0),
      .HAS_EDGE_IRQ(p == 0)
    ) u_cell (
      .clk(clk),
      .rst(rst),
      .set(set_reg[p]),
      .ded_level(ded_src[p]),
      .alt_level(alt_src[p]),
      .pad_in(pad_in[p]),
      .drive(drive[p])
    );
    assign pad_out[p] = drive[p].pad_out;
    assign pad_oe[p] = drive[p].pad_oe;
  end

  assign rdata = rdata_reg;
  assign resp_valid = resp_valid_reg;
  assign analog_input_one = drive[0].ain_en;
  assign analog_input_two = drive[1].ain_en;
  assign analog_input_three = drive[2].ain_en;
  assign analog_output_one = drive[1].aout_en;
  assign analog_output_two = drive[2].aout_en;
  assign edge_input_en = drive[0].edge_en;
  assign edge_input_level = drive[0].in_level;

  chk_alter_loads: assert property (@(posedge clk) disable iff (rst)
    (state_reg == gpfs_pkg::ST_APPLY && cmd_ok_reg && cmd_reg[7][7])
    |=> (set_reg[1] == gpfs_pkg::gpfs_pin_set_type'(cmd_reg[10][4:0])))
    else $error("pin settings not loaded with alter flag set");
  chk_no_alter_hold: assert property (@(posedge clk) disable iff (rst)
    (state_reg != gpfs_pkg::ST_APPLY || !cmd_ok_reg || !cmd_reg[7][7])
    |=> $stable(set_reg[0]) && $stable(set_reg[2]))
    else $error("pin settings changed without alter flag");
  chk_reply_echo: assert property (@(posedge clk) disable iff (rst)
    (go && cmd_reg[0] == 8'h60) |-> ##4 (resp_valid && resp0_reg == 8'h60 && resp1_reg == 8'h00))
    else $error("reply not echoing code with success status");
  chk_pins_together: assert property (@(posedge clk) disable iff (rst)
    $changed(set_reg[0]) || $changed(set_reg[2]) |-> $past(state_reg) == gpfs_pkg::ST_APPLY)
    else $error("pin settings changed outside apply cycle");
  chk_second_pin_out: assert property (@(posedge clk) disable iff (rst)
    (set_reg[1].func == 3'h0 && !set_reg[1].dir_in) |=> (pad_oe[1] && pad_out[1] == $past(set_reg[1].out_val)))
    else $error("second pin gpio output wrong");
  chk_second_pin_dir: assert property (@(posedge clk) disable iff (rst)
    (set_reg[1].func == 3'h0 && set_reg[1].dir_in) |=> !pad_oe[1])
    else $error("second pin input drives pad");
  chk_second_pin_dac: assert property (@(posedge clk) disable iff (rst)
    (set_reg[1].func == 3'h3) |=> (analog_output_one && !pad_oe[1]))
    else $error("second pin analog output not routed");
  chk_third_pin_out: assert property (@(posedge clk) disable iff (rst)
    (set_reg[2].func == 3'h0 && !set_reg[2].dir_in) |=> (pad_oe[2] && pad_out[2] == $past(set_reg[2].out_val)))
    else $error("third pin gpio output wrong");
  chk_third_pin_dir: assert property (@(posedge clk) disable iff (rst)
    (set_reg[2].func == 3'h0 && set_reg[2].dir_in) |=> !pad_oe[2])
    else $error("third pin input drives pad");
  chk_third_pin_led: assert property (@(posedge clk) disable iff (rst)
    (set_reg[2].func == 3'h1) |=> (pad_oe[2] && pad_out[2] == $past(serial_bus_activity_indicator)))
    else $error("third pin bus led not routed");
  chk_first_pin_edge: assert property (@(posedge clk) disable iff (rst)
    (set_reg[0].func == 3'h4) |=> (edge_input_en && !pad_oe[0]))
    else $error("first pin edge input not routed");

  cov_apply_alter: cover property (@(posedge clk) disable iff (rst)
    state_reg == gpfs_pkg::ST_APPLY && cmd_ok_reg && cmd_reg[7][7]);
  cov_bad_command: cover property (@(posedge clk) disable iff (rst)
    resp_valid && resp1_reg == gpfs_pkg::RESP_BAD_CMD);
  cov_edge_mode: cover property (@(posedge clk) disable iff (rst) edge_input_en);
  cov_all_outputs: cover property (@(posedge clk) disable iff (rst) pad_oe == 3'h7);

endmodule

// ===== test/gpfs_host_model.sv
`timescale 1ns/100ps
// host side of the settings exchange: owns the register port strobes
module gpfs_host_model (
  input wire logic clk, // system clock
  input wire logic [7:0] rdata, // read data from the block
  input wire logic resp_valid, // reply posted pulse
  output logic [7:0] addr, // register address
  output logic [7:0] wdata, // write data
  output logic wr_en, // write strobe
  output logic rd_en // read strobe
);
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end

  // one cycle write, strobe dropped at the next edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    d = rdata;
  endtask

  // full settings command, waits a bounded time for the reply pulse
  task automatic send(input logic [7:0] cmd, input logic [7:0] alter, input logic [7:0] b9,
                      input logic [7:0] b10, input logic [7:0] b11, output logic ok);
    int n;
    wr(gpfs_pkg::ADDR_CMD_FIRST, cmd);
    wr(8'h07, alter);
    wr(8'h09, b9);
    wr(8'h0a, b10);
    wr(8'h0b, b11);
    wr(gpfs_pkg::ADDR_CONTROL, 8'h01);
    ok = 1'b0;
    n = 0;
    // no reply within a few cycles means the sequencer hung
    while (!ok && n < 12) begin
      #1;
      ok = (resp_valid === 1'b1);
      if (!ok) begin
        @(posedge clk);
      end
      n++;
    end
  endtask
endmodule

// ===== test/gpfs_pin_function_select_tb.sv
`timescale 1ns/100ps
module gpfs_pin_function_select_tb;
  logic clk;
  logic rst;
  logic [2:0] pad_in;
  logic clk_src, tx_src, usb_src, bus_src;
  wire logic [7:0] addr, wdata, rdata;
  wire logic wr_en, rd_en, resp_valid;
  logic [2:0] pad_out, pad_oe;
  logic ain1, ain2, ain3, aout1, aout2, edge_en, edge_lvl;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  logic [7:0] d;
  logic ok;
  logic [2:0] exp_oe [1:4] = '{3'b111, 3'b000, 3'b001, 3'b000};
  logic [2:0] exp_out [1:4] = '{3'b101, 3'b000, 3'b001, 3'b000};
  logic [5:0] exp_en [1:4] = '{6'h00, 6'h07, 6'h18, 6'h20};
  wire logic [5:0] en_o = {edge_en, aout2, aout1, ain3, ain2, ain1};

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  gpfs_pin_function_select dut (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .resp_valid(resp_valid), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe(pad_oe), .clock_out_level(clk_src), .transmit_activity_indicator(tx_src),
    .usb_configured_indicator(usb_src), .serial_bus_activity_indicator(bus_src),
    .analog_input_one(ain1), .analog_input_two(ain2), .analog_input_three(ain3),
    .analog_output_one(aout1), .analog_output_two(aout2), .edge_input_en(edge_en),
    .edge_input_level(edge_lvl)
  );

  gpfs_host_model host (
    .clk(clk), .rdata(rdata), .resp_valid(resp_valid), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en)
  );

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask

  task automatic final_report;
    if (num_errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // cut a hang short; the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles >= 3000) begin
      num_errors++;
      final_report();
    end
  end

  // reply bytes: echo of the code and the status
  task automatic chk_reply(input logic [7:0] e0, input logic [7:0] e1);
    chk("reply valid", 8'h01, {7'h0, ok});
    host.rd(gpfs_pkg::ADDR_RESP0, d);
    chk("reply byte0", e0, d);
    host.rd(gpfs_pkg::ADDR_RESP1, d);
    chk("reply byte1", e1, d);
  endtask

  initial begin
    rst = 1'b1;
    pad_in = 3'b101;
    clk_src = 1'b1;
    tx_src = 1'b1;
    usb_src = 1'b0;
    bus_src = 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    // reset leaves every pin a general purpose input
    for (int p = 0; p < 3; p++) begin
      host.rd(gpfs_pkg::ADDR_PIN_SET_FIRST + 8'(p), d);
      chk("reset settings", 8'h08, d);
    end
    chk("reset oe", 8'h00, {5'h0, pad_oe});
    chk("reset owners", 8'h00, {2'h0, en_o});
    // gpio: pin one out high, pin two out low, pin three input; junk in bits 7-5
    host.send(8'h60, 8'h80, 8'hf0, 8'he0, 8'h38, ok);
    chk_reply(8'h60, 8'h00);
    chk("gpio oe", 8'h03, {5'h0, pad_oe});
    chk("gpio out", 8'h01, {5'h0, pad_out & pad_oe});
    host.rd(gpfs_pkg::ADDR_PIN_SET_FIRST, d);
    chk("pin one settings", 8'h10, d);
    host.rd(8'h33, d);
    chk("pin three settings", 8'h18, d);
    // flag clear: settings must not move
    host.send(8'h60, 8'h00, 8'h03, 8'h03, 8'h03, ok);
    chk_reply(8'h60, 8'h00);
    chk("no alter oe", 8'h03, {5'h0, pad_oe});
    host.rd(gpfs_pkg::ADDR_PIN_SET_FIRST, d);
    chk("no alter settings", 8'h10, d);
    // wrong command code is refused
    host.send(8'h61, 8'h80, 8'h02, 8'h02, 8'h02, ok);
    chk_reply(8'h61, 8'h01);
    chk("bad cmd oe", 8'h03, {5'h0, pad_oe});
    // function codes 001 to 100 on all three pins, direction set to output to show it is ignored
    for (int c = 1; c <= 4; c++) begin
      host.send(8'h60, 8'h80, 8'hb0 | 8'(c), 8'hb0 | 8'(c), 8'hb0 | 8'(c), ok);
      chk("func oe", {5'h0, exp_oe[c]}, {5'h0, pad_oe});
      chk("func out", {5'h0, exp_out[c]}, {5'h0, pad_out & pad_oe});
      chk("func owners", {2'h0, exp_en[c]}, {2'h0, en_o});
      for (int p = 0; p < 3; p++) begin
        host.rd(gpfs_pkg::ADDR_PIN_SET_FIRST + 8'(p), d);
        chk("func settings", 8'h10 | 8'(c), d);
      end
    end
    // reserved codes leave every pad undriven and every owner off
    host.send(8'h60, 8'h80, 8'h15, 8'h16, 8'h17, ok);
    chk("reserved oe", 8'h00, {5'h0, pad_oe});
    chk("reserved owners", 8'h00, {2'h0, en_o});
    // pin one back to input, pins two and three drive high
    host.send(8'h60, 8'h80, 8'h08, 8'h10, 8'h10, ok);
    chk_reply(8'h60, 8'h00);
    chk("gpio high oe", 8'h06, {5'h0, pad_oe});
    chk("gpio high out", 8'h06, {5'h0, pad_out & pad_oe});
    // pad levels and the edge detector copy
    chk("edge level", 8'h01, {7'h0, edge_lvl});
    host.rd(gpfs_pkg::ADDR_PIN_LEVELS, d);
    chk("pad levels", 8'h05, d);
    // move the pads so a stuck copy shows up
    @(posedge clk);
    pad_in <= 3'b010;
    host.rd(gpfs_pkg::ADDR_PIN_LEVELS, d);
    chk("pad levels new", 8'h02, d);
    chk("edge level new", 8'h00, {7'h0, edge_lvl});
    host.rd(8'h40, d);
    chk("unmapped read", 8'h00, d);
    final_report();
  end
endmodule
